/* File: inc/bsp_defines.svh */
// register map, field positions and constants for the sensor and progress block
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH
`define BSP_OFF_SENSE     12'h000
`define BSP_OFF_MISC      12'h004
`define BSP_OFF_PROGCODE  12'h008
`define BSP_OFF_PROGCTRL  12'h00C
`define BSP_OFF_FIFOSTAT  12'h010
`define BSP_OFF_FIFOREAD  12'h014
`define BSP_OFF_STAMP     12'h018
`define BSP_OFF_POH       12'h01C
`define BSP_OFF_EVENT     12'h020
`define BSP_OFF_TIME      12'h024
`define BSP_EVT_SENSOR    8'h09
`define BSP_EVT_TYPE      8'hE6
`define BSP_EVT_OFFSET    8'h04
`define BSP_TERM_SENSOR   8'h07
`define BSP_TERM_TYPE     8'h08
`define BSP_CLK_HZ        50000000
`define BSP_SEC_PER_HOUR  3600
`define BSP_BEEP_MS       200
`define BSP_MS_PER_SEC    1000
`define BSP_HOUR_CNT_W    40
`define BSP_CODE_FORCE    16
`define BSP_CLR_FIFO      0
`define BSP_EVT_AC_BIT    0
`define BSP_EVT_DIAG_BIT  1
`define BSP_RESP_OKAY     2'b00
`define BSP_RESP_SLVERR   2'b10
`endif

/* File: inc/bsp_pkg.sv */
// types shared by the sensor and progress block
package bsp_pkg;
   typedef enum logic [1:0] {BEEP_NONE, BEEP_SOCKET, BEEP_VID} bsp_beep_t;
endpackage

/* File: verilog/bsp_sensor_fifo.sv */
// board sensor readout, event latch and progress code fifo behind an axi4-lite slave
`timescale 1ns/1ps
`include "bsp_defines.svh"
module bsp_sensor_fifo
   import bsp_pkg::*;
#(
   parameter int DEPTH      = 16,
   parameter int CODE_W     = 8,
   parameter longint HOUR_TICKS = longint'(`BSP_CLK_HZ) * `BSP_SEC_PER_HOUR,
   parameter int BEEP_TICKS = (`BSP_CLK_HZ / `BSP_MS_PER_SEC) * `BSP_BEEP_MS
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // axi4-lite write address and data
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // processor sockets
   input  wire logic [1:0]        socketPopulated,
   input  wire logic [1:0]        cpuPresent,
   input  wire logic [1:0]        processor_internal_error,
   input  wire logic [1:0]        cpuThermalTrip,
   input  wire logic              vidMismatch,
   // board inputs
   input  wire logic [5:0]        dimmPresent,
   input  wire logic              chassisIntrusion,
   input  wire logic              powerButton,
   input  wire logic              resetButton,
   input  wire logic              diagInterrupt,
   input  wire logic              keyboard_secure_request,
   input  wire logic              smiLine,
   input  wire logic              nmiLine,
   // power state
   input  wire logic              powerUpRequest,
   input  wire logic              mainsGood,
   input  wire logic              sleepS4S5,
   input  wire logic              systemReset,
   input  wire logic              systemOn,
   // outputs
   output logic                   diagNmiOut,
   output logic                   secureMode,
   output logic                   beepActive,
   output logic [1:0]             beepCause
);
   localparam int AW = $clog2(DEPTH);
   // an hour of clock ticks does not fit 32 bits, so the prescaler is wider
   localparam int CW = `BSP_HOUR_CNT_W;

   // refuse sizes that the fixed bus fields and counters cannot carry
   if (DEPTH != 16 || CODE_W < 1 || CODE_W > 16 || HOUR_TICKS < 2
       || HOUR_TICKS >= (longint'(1) << CW) || BEEP_TICKS < 2)
   begin : gParamCheck
      $error("bsp_sensor_fifo: unsupported parameters");
   end

   // bus handshake state
   logic              awHeld_r;
   logic              wHeld_r;
   logic [11:0]       awAddr_r;
   logic [31:0]       wData_r;
   logic [3:0]        wStrb_r;
   logic              bValid_r;
   logic              rValid_r;
   logic [31:0]       rData_r;
   logic [1:0]        rResp_r;
   logic [1:0]        bResp_r;
   // block state
   logic [CODE_W-1:0] fifoMem [DEPTH];
   logic [AW-1:0]     wrPtr_r;
   logic [AW-1:0]     rdIdx_r;
   logic [AW:0]       count_r;
   logic [CODE_W-1:0] lastCode_r;
   logic              haveCode_r;
   logic [31:0]       stamp_r;
   logic [31:0]       timeNow_r;
   logic [31:0]       poh_r;
   logic [CW-1:0]     hourCnt_r;
   logic [31:0]       beepCnt_r;
   bsp_beep_t         beep_r;
   logic              mainsPrev_r;
   logic              acEvent_r;
   logic              diagPrev_r;
   logic              diagEvent_r;
   logic              nmiOut_r;
   logic              secure_r;

   logic              wrFire;
   logic              rdFire;
   logic              codeWrite;
   logic              forceStore;
   logic [CODE_W-1:0] newCode;
   logic              storeCode;
   logic              fifoClear;
   logic [31:0]       rdMux;
   logic              rdOk;
   logic              wrOk;

   // write channels may arrive in either order; response waits for both
   assign s_axi_awready = !awHeld_r && !bValid_r;
   assign s_axi_wready  = !wHeld_r && !bValid_r;
   assign wrFire        = awHeld_r && wHeld_r && !bValid_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_arready = !rValid_r;
   assign rdFire        = s_axi_arvalid && !rValid_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rdata   = rData_r;
   assign s_axi_rresp   = rResp_r;

   // capture address and data independently
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= 12'h000;
         wData_r  <= 32'h0000_0000;
         wStrb_r  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         else if (wrFire)
            awHeld_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         else if (wrFire)
            wHeld_r <= 1'b0;
      end
   end

   // writable addresses decode
   always_comb
   begin
      unique case (awAddr_r)
         `BSP_OFF_PROGCODE,
         `BSP_OFF_PROGCTRL,
         `BSP_OFF_FIFOREAD,
         `BSP_OFF_EVENT:    wrOk = 1'b1;
         default:           wrOk = 1'b0;
      endcase
   end

   // write response, slverr for unmapped or read-only words
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bValid_r <= 1'b0;
         bResp_r  <= `BSP_RESP_OKAY;
      end
      else if (wrFire)
      begin
         bValid_r <= 1'b1;
         bResp_r  <= wrOk ? `BSP_RESP_OKAY : `BSP_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bValid_r <= 1'b0;
   end

   // progress code write: low byte lane carries code, bit 16 forces a duplicate
   assign codeWrite  = wrFire && awAddr_r == `BSP_OFF_PROGCODE && wStrb_r[0];
   assign newCode    = wData_r[CODE_W-1:0];
   assign forceStore = wData_r[`BSP_CODE_FORCE];
   assign storeCode  = codeWrite && (forceStore || !haveCode_r || newCode != lastCode_r);
   // volatile: several system conditions wipe it, software can too via ctrl bit 0
   assign fifoClear  = !mainsGood || sleepS4S5 || systemReset
                       || (wrFire && awAddr_r == `BSP_OFF_PROGCTRL
                           && wData_r[`BSP_CLR_FIFO]);

   // fifo storage, a ring that overwrites the oldest slot when full
   always_ff @(posedge clk)
   begin
      if (storeCode && !fifoClear)
         fifoMem[wrPtr_r] <= newCode;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr_r    <= '0;
         count_r    <= '0;
         lastCode_r <= '0;
         haveCode_r <= 1'b0;
         stamp_r    <= 32'h0000_0000;
      end
      else if (fifoClear)
      begin
         wrPtr_r    <= '0;
         count_r    <= '0;
         haveCode_r <= 1'b0;
      end
      else if (storeCode)
      begin
         wrPtr_r    <= wrPtr_r + 1'b1;
         if (count_r != (AW+1)'(DEPTH))
            count_r <= count_r + 1'b1;
         lastCode_r <= newCode;
         haveCode_r <= 1'b1;
         stamp_r    <= timeNow_r;
      end
   end

   // read index for walking the fifo, written by software, 0 is oldest
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdIdx_r <= '0;
      else if (wrFire && awAddr_r == `BSP_OFF_FIFOREAD)
         rdIdx_r <= wData_r[AW-1:0];
   end

   // free running seconds-free tick count used as timestamp base
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         timeNow_r <= 32'h0000_0000;
      else
         timeNow_r <= timeNow_r + 32'h0000_0001;
   end

   // powered-on hours, counts only while system power is on
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hourCnt_r <= '0;
         poh_r     <= 32'h0000_0000;
      end
      else if (systemOn)
      begin
         if (hourCnt_r == CW'(HOUR_TICKS - 1))
         begin
            hourCnt_r <= '0;
            poh_r     <= poh_r + 32'h0000_0001;
         end
         else
            hourCnt_r <= hourCnt_r + 1'b1;
      end
   end

   // beep on power-up attempt; vid mismatch wins since a socket fault may be its cause
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         beep_r    <= BEEP_NONE;
         beepCnt_r <= 32'h0000_0000;
      end
      else if (powerUpRequest && beepCnt_r == 32'h0000_0000 && vidMismatch)
      begin
         beep_r    <= BEEP_VID;
         beepCnt_r <= 32'(BEEP_TICKS);
      end
      else if (powerUpRequest && beepCnt_r == 32'h0000_0000 && !(&socketPopulated))
      begin
         beep_r    <= BEEP_SOCKET;
         beepCnt_r <= 32'(BEEP_TICKS);
      end
      else if (beepCnt_r != 32'h0000_0000)
      begin
         beepCnt_r <= beepCnt_r - 32'h0000_0001;
         if (beepCnt_r == 32'h0000_0001)
            beep_r <= BEEP_NONE;
      end
   end
   assign beepActive = beep_r != BEEP_NONE;
   assign beepCause  = beep_r;

   // sticky events; hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mainsPrev_r <= 1'b1;
         acEvent_r   <= 1'b0;
         diagPrev_r  <= 1'b0;
         diagEvent_r <= 1'b0;
      end
      else
      begin
         mainsPrev_r <= mainsGood;
         diagPrev_r  <= diagInterrupt;
         if (mainsGood && !mainsPrev_r)
            acEvent_r <= 1'b1;
         else if (wrFire && awAddr_r == `BSP_OFF_EVENT && wData_r[`BSP_EVT_AC_BIT])
            acEvent_r <= 1'b0;
         if (diagInterrupt && !diagPrev_r)
            diagEvent_r <= 1'b1;
         else if (wrFire && awAddr_r == `BSP_OFF_EVENT && wData_r[`BSP_EVT_DIAG_BIT])
            diagEvent_r <= 1'b0;
      end
   end

   // separate nmi drive and secure mode follow their inputs one clock later
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         nmiOut_r <= 1'b0;
         secure_r <= 1'b0;
      end
      else
      begin
         nmiOut_r <= diagInterrupt;
         secure_r <= keyboard_secure_request;
      end
   end
   assign diagNmiOut = nmiOut_r;
   assign secureMode = secure_r;

   // read mux; raw inputs are sampled at the read, no level history kept
   always_comb
   begin
      rdMux = 32'h0000_0000;
      rdOk  = 1'b1;
      unique case (s_axi_araddr)
         `BSP_OFF_SENSE:
            rdMux = {18'h00000, dimmPresent,
                     cpuThermalTrip[1], processor_internal_error[1], cpuPresent[1],
                     cpuThermalTrip[0], processor_internal_error[0], cpuPresent[0],
                     socketPopulated};
         `BSP_OFF_MISC:
            // open input pulls high, so high means insecure
            rdMux = {24'h000000, nmiLine, smiLine, keyboard_secure_request,
                     resetButton, powerButton, chassisIntrusion, 2'b00};
         `BSP_OFF_PROGCODE: rdMux = {15'h0000, haveCode_r, 16'(lastCode_r)};
         `BSP_OFF_FIFOSTAT: rdMux = {16'h0000, 8'(rdIdx_r), 8'(count_r)};
         `BSP_OFF_FIFOREAD:
            rdMux = 32'(fifoMem[AW'(wrPtr_r - AW'(count_r) + rdIdx_r)]);
         `BSP_OFF_STAMP:    rdMux = stamp_r;
         `BSP_OFF_POH:      rdMux = poh_r;
         `BSP_OFF_EVENT:
            rdMux = {`BSP_EVT_SENSOR, `BSP_EVT_TYPE, `BSP_EVT_OFFSET,
                     6'h00, diagEvent_r, acEvent_r};
         `BSP_OFF_TIME:
            rdMux = {16'h0000, `BSP_TERM_SENSOR, `BSP_TERM_TYPE};
         default:           rdOk  = 1'b0;
      endcase
   end

   // read data registered, held until rready
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rValid_r <= 1'b0;
         rData_r  <= 32'h0000_0000;
         rResp_r  <= `BSP_RESP_OKAY;
      end
      else if (rdFire)
      begin
         rValid_r <= 1'b1;
         rData_r  <= rdMux;
         rResp_r  <= rdOk ? `BSP_RESP_OKAY : `BSP_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rValid_r <= 1'b0;
   end
endmodule

/* File: verification/bsp_sensor_fifo_chk.sv */
// concurrent checks on the sensor and progress block ports
`timescale 1ns/1ps
module bsp_sensor_fifo_chk
   import bsp_pkg::*;
#(
   parameter int BEEP_TICKS = 20
)(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // bus handshakes
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   // board side
   input wire logic       diagInterrupt,
   input wire logic       diagNmiOut,
   input wire logic       keyboard_secure_request,
   input wire logic       secureMode,
   input wire logic       powerUpRequest,
   input wire logic [1:0] socketPopulated,
   input wire logic       vidMismatch,
   input wire logic       beepActive,
   input wire logic [1:0] beepCause
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [31:0] beepCnt_r;
   // length of the running beep, so a stuck speaker shows up
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         beepCnt_r <= '0;
      else
         beepCnt_r <= beepActive ? beepCnt_r + 32'h1 : '0;
   end
   sequence sWrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence sBeep(logic [1:0] c);
      ##[1:3] (beepActive && beepCause == c);
   endsequence
   a_write_answer: assert property (sWrTaken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_nmi_follow: assert property ($changed(diagInterrupt) |=> diagNmiOut == $past(diagInterrupt))
      else $error("nmi output does not follow diagnostic input");
   a_secure_follow: assert property ($rose(keyboard_secure_request) |=> $rose(secureMode))
      else $error("secure mode not entered");
   a_socket_beep: assert property (powerUpRequest && socketPopulated != 2'h3
      && !vidMismatch && !beepActive |-> sBeep(BEEP_SOCKET))
      else $error("empty socket did not beep");
   a_vid_beep: assert property (powerUpRequest && vidMismatch && !beepActive |-> sBeep(BEEP_VID))
      else $error("voltage mismatch did not beep");
   a_beep_length: assert property ($fell(beepActive) |-> beepCnt_r == BEEP_TICKS)
      else $error("beep length wrong");
endmodule

/* File: verification/bsp_board_model.sv */
// board side model: socket modules and the intrusion switch line
`timescale 1ns/1ps
module bsp_board_model
(
   // socket contents
   input  wire logic [1:0] cpuPresent,
   input  wire logic [1:0] termSeated,
   // intrusion switch
   input  wire logic       intrusionWired,
   input  wire logic       intrusionLevel,
   // lines toward the block
   output logic [1:0]      socketPopulated,
   output logic            chassisIntrusion
);
   // either a processor or a terminator fills a socket
   assign socketPopulated = cpuPresent | termSeated;
   // an unwired switch line floats up, which must read insecure
   assign chassisIntrusion = intrusionWired ? intrusionLevel : 1'b1;
endmodule

/* File: verification/bsp_sensor_fifo_test.sv */
// self-checking bench for the sensor and progress block
`timescale 1ns/1ps
`include "bsp_defines.svh"
module bsp_sensor_fifo_test;
   import bsp_pkg::*;
   logic        clk = 1'b0, rst = 1'b1;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, s;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, beepCause, rsp, socketPopulated;
   logic [1:0]  cpuPresent = 0, processor_internal_error = 0, cpuThermalTrip = 0, termSeated = 0;
   logic [5:0]  dimmPresent = 0;
   logic        vidMismatch = 0, powerButton = 0, resetButton = 0, diagInterrupt = 0;
   logic        keyboard_secure_request = 0, smiLine = 0, nmiLine = 0, powerUpRequest = 0;
   logic        mainsGood = 1, sleepS4S5 = 0, systemReset = 0, systemOn = 0;
   logic        intrusionWired = 1, intrusionLevel = 0, chassisIntrusion;
   logic        diagNmiOut, secureMode, beepActive;
   logic [2:0]  clr [3] = '{3'b101, 3'b110, 3'b001};
   int          errors = 0, checks = 0;
   // short counts keep the hour and beep timers inside the run
   bsp_sensor_fifo #(.HOUR_TICKS(100), .BEEP_TICKS(20)) u_bsp_sensor_fifo (.clk, .rst,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .socketPopulated, .cpuPresent, .processor_internal_error,
      .cpuThermalTrip, .vidMismatch, .dimmPresent, .chassisIntrusion, .powerButton,
      .resetButton, .diagInterrupt, .keyboard_secure_request, .smiLine, .nmiLine,
      .powerUpRequest, .mainsGood, .sleepS4S5, .systemReset, .systemOn, .diagNmiOut,
      .secureMode, .beepActive, .beepCause);
   bsp_board_model u_bsp_board_model (.cpuPresent, .termSeated, .intrusionWired,
      .intrusionLevel, .socketPopulated, .chassisIntrusion);
   always #10 clk = ~clk;
   task summarize;
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // write: address and data offered together, each dropped once taken
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
   endtask
   task rdw(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task pc(input logic [7:0] c, input logic f);
      wr(`BSP_OFF_PROGCODE, {15'h0, f, 8'h0, c});
   endtask
   task ent(input logic [3:0] i, input logic [7:0] c);
      wr(`BSP_OFF_FIFOREAD, {28'h0, i});
      rdw(`BSP_OFF_FIFOREAD);
      chk(rd & 32'hFF, {24'h0, c});
   endtask
   task cnt(input logic [7:0] c);
      rdw(`BSP_OFF_FIFOSTAT);
      chk(rd & 32'hFF, {24'h0, c});
   endtask
   // power-up attempt with given terminators and voltage match
   task pu(input logic [1:0] t, input logic v, input logic [1:0] e);
      termSeated <= t;
      vidMismatch <= v;
      tk(3);
      powerUpRequest <= 1'b1;
      tk(1);
      powerUpRequest <= 1'b0;
      tk(4);
      chk({30'h0, beepCause}, {30'h0, e});
      chk({31'h0, beepActive}, {31'h0, e != BEEP_NONE});
      tk(30);
   endtask
   // watchdog at 20000 cycles, generous against the well under a thousand cycles of tests
   initial
   begin
      #400000;
      errors++;
      summarize;
   end
   initial
   begin
      tk(6);
      rst <= 1'b0;
      cpuPresent <= 2'h1;
      termSeated <= 2'h2;
      processor_internal_error <= 2'h2;
      cpuThermalTrip <= 2'h1;
      dimmPresent <= 6'h2D;
      tk(3);
      rdw(`BSP_OFF_SENSE);
      chk(rd, 32'h0000_2D57);
      for (int i = 0; i < 6; i++)
      begin
         {nmiLine, smiLine, keyboard_secure_request, resetButton, powerButton,
            intrusionLevel} <= 6'h1 << i;
         tk(3);
         rdw(`BSP_OFF_MISC);
         chk(rd, 32'h4 << i);
      end
      intrusionWired <= 1'b0;
      nmiLine <= 1'b0;
      tk(3);
      rdw(`BSP_OFF_MISC);
      chk(rd, 32'h4);
      rdw(`BSP_OFF_TIME);
      chk(rd, 32'h0000_0708);
      rdw(12'h100);
      chk({30'h0, rsp}, {30'h0, `BSP_RESP_SLVERR});
      wr(`BSP_OFF_SENSE, 32'h1);
      chk({30'h0, rsp}, {30'h0, `BSP_RESP_SLVERR});
      wr(`BSP_OFF_PROGCTRL, 32'h1);
      pc(8'h11, 0);
      rdw(`BSP_OFF_STAMP);
      s = rd;
      pc(8'h11, 0);
      rdw(`BSP_OFF_STAMP);
      chk(rd, s);
      pc(8'h11, 1);
      pc(8'h22, 0);
      rdw(`BSP_OFF_STAMP);
      chk({31'h0, rd != s}, 32'h1);
      cnt(8'h3);
      ent(4'h1, 8'h11);
      ent(4'h2, 8'h22);
      rdw(`BSP_OFF_PROGCODE);
      chk(rd & 32'h1FFFF, 32'h1_0022);
      // a code write without the low byte lane must not store
      s_axi_wstrb <= 4'h0;
      pc(8'h33, 1);
      s_axi_wstrb <= 4'hF;
      cnt(8'h3);
      for (int i = 1; i <= 18; i++)
         pc(i[7:0], 0);
      cnt(8'h10);
      ent(4'h0, 8'h03);
      ent(4'hF, 8'h12);
      // each system clearing cause in turn: system reset, sleep, then mains loss with system reset also held
      for (int k = 0; k < 3; k++)
      begin
         pc(8'h40, 1);
         {mainsGood, sleepS4S5, systemReset} <= clr[k];
         tk(4);
         {mainsGood, sleepS4S5, systemReset} <= 3'b100;
         tk(4);
         cnt(8'h0);
      end
      rdw(`BSP_OFF_EVENT);
      chk(rd, 32'h09E6_0401);
      wr(`BSP_OFF_EVENT, 32'h3);
      diagInterrupt <= 1'b1;
      tk(2);
      diagInterrupt <= 1'b0;
      tk(2);
      rdw(`BSP_OFF_EVENT);
      chk(rd, 32'h09E6_0402);
      systemOn <= 1'b1;
      tk(250);
      systemOn <= 1'b0;
      rdw(`BSP_OFF_POH);
      chk(rd, 32'h2);
      pu(2'h0, 1'b0, BEEP_SOCKET);
      pu(2'h2, 1'b1, BEEP_VID);
      pu(2'h2, 1'b0, BEEP_NONE);
      summarize;
   end
endmodule
bind bsp_sensor_fifo bsp_sensor_fifo_chk #(.BEEP_TICKS(BEEP_TICKS)) u_bsp_sensor_fifo_chk (
   .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .diagInterrupt, .diagNmiOut,
   .keyboard_secure_request, .secureMode, .powerUpRequest, .socketPopulated, .vidMismatch,
   .beepActive, .beepCause);
